// >>> hw/gdp_bank.sv
// gdp_bank: three configuration registers, a shutdown scope register, a status register, a lock, and the overcurrent
// deglitch / response / retry sequencer that the settings steer.
// assumes synchronous inputs on ref_clk and a master that never overlaps strobes.
//
// Notes on behaviour
// R1 - pwm edge clears an auto-retry fault early only if cycle clear set
// R2 - peak drive time code 00..11 selects 500..4000 ns, resets to 11
// R3 - low-side source current code, resets to 1111
// R4 - low-side sink current code, resets to 1111
// R5 - retry interval 8 ms when bit clear (reset), 50 us when set
// R6 - dead time code 00..11 selects 50..400 ns, resets to 01
// R7 - response 00 latches the fault until explicitly cleared
// R8 - response 01 (reset) retries automatically after the retry condition
// R9 - response 10 reports only, outputs not shut down
// R10 - response 11 neither reports nor acts
// R11 - overcurrent must persist 1, 2, 4 or 8 us; resets to code 10
// R12 - drain-source threshold code, resets to 1001
// R13 - amp input select routes switch node and forces low-side reference to one
// R14 - reference divide bit: full reference at 0, half at 1 (reset)
// R15 - low-side reference selects shunt-positive (0) or shunt-negative (1)
// R16 - amplifier gain code 00..11 gives 5..40 V/V, resets to 10
// R17 - shunt fault disable suppresses shunt overcurrent when set
// R18 - per-phase calibration bits short that amplifier's inputs
// R19 - shunt trip threshold code 00..11, resets to 11
// R20 - amplifier register exists only when the amplifier variant is built
// R21 - writes ignored while locked; 110 locks, 011 unlocks
// R22 - shutdown scope: affected half-bridge at 0, all three at 1
// R23 - every stored field bit reads back exactly as written; low-side reference reads 1 whenever amp input select was written set
`timescale 1ns/1ns
module gdp_bank #(
    parameter bit          HAS_AMP   = 1'b1,
    parameter int unsigned RETRY_LONG = gdp_pkg::RETRY_LONG_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  addr,
    input  wire logic [10:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [10:0] rdata,
    input  wire logic [2:0]  drain_source_overcurrent,
    input  wire logic [2:0]  shunt_overcurrent,
    input  wire logic        pwm_edge,
    input  wire logic        fault_clear,
    output logic      [2:0]  bridge_shutdown,
    output logic             fault_report,
    output logic      [10:0] low_side_drive_cfg,
    output logic      [10:0] overcurrent_cfg,
    output logic      [10:0] sense_amp_cfg
);
    typedef struct packed {
        logic [10:0]         ls;
        logic [10:0]         oc;
        logic [10:0]         sa;
        logic                locked;
        logic                scope;
        logic [10:0]         rdata;
        gdp_pkg::gdp_state_t st;
        logic [17:0]         cnt;
        logic [2:0]          phase;
        logic [2:0]          shut;
        logic                rep;
    } gdp_state_s_t;

    gdp_state_s_t s_q;
    gdp_state_s_t s_d;

    // deglitch length in cycles: 1 us doubled per code step
    function automatic logic [17:0] deg_cycles(input logic [1:0] code);
        deg_cycles = 18'(gdp_pkg::DEG_BASE_CYC) << code;
    endfunction

    logic [2:0] oc_raw;
    logic [1:0] resp;
    logic       sen_en;

    always_comb begin
        s_d     = s_q;
        resp    = s_q.oc[gdp_pkg::OC_MODE +: 2];
        sen_en  = HAS_AMP && !s_q.sa[gdp_pkg::SA_DIS]; // R17
        oc_raw  = drain_source_overcurrent | (sen_en ? shunt_overcurrent : 3'h0);
        s_d.rdata = 11'h000;
        if (rd_en) begin
            case (addr)
                gdp_pkg::ADDR_LS_DRIVE: s_d.rdata = s_q.ls; // R23
                gdp_pkg::ADDR_OC_CFG:   s_d.rdata = s_q.oc;
                gdp_pkg::ADDR_SA_CFG:   s_d.rdata = HAS_AMP ? s_q.sa : 11'h000; // R20
                gdp_pkg::ADDR_LOCK:     s_d.rdata = {10'h000, s_q.locked};
                gdp_pkg::ADDR_STATUS:   s_d.rdata = {5'h00, s_q.st == gdp_pkg::ST_FAULT,
                                                     s_q.rep, s_q.shut, 1'b0};
                gdp_pkg::ADDR_ACTION:   s_d.rdata = {10'h000, s_q.scope};
                default:                s_d.rdata = 11'h000;
            endcase
        end
        if (wr_en) begin
            if (addr == gdp_pkg::ADDR_LOCK) begin
                if (!s_q.locked && wdata[2:0] == gdp_pkg::LOCK_CODE) begin
                    s_d.locked = 1'b1; // R21
                end else if (s_q.locked && wdata[2:0] == gdp_pkg::UNLOCK_CODE) begin
                    s_d.locked = 1'b0; // R21
                end
            end else if (!s_q.locked) begin // R21
                case (addr)
                    gdp_pkg::ADDR_LS_DRIVE: s_d.ls = wdata; // R2 R3 R4
                    gdp_pkg::ADDR_OC_CFG:   s_d.oc = wdata; // R5 R6 R11 R12
                    gdp_pkg::ADDR_SA_CFG: begin
                        if (HAS_AMP) begin
                            s_d.sa = wdata; // R14 R16 R18 R19
                            if (wdata[gdp_pkg::SA_FET]) begin
                                s_d.sa[gdp_pkg::SA_LSREF] = 1'b1; // R13
                            end
                        end
                    end
                    gdp_pkg::ADDR_ACTION:   s_d.scope = wdata[0];
                    default: ;
                endcase
            end
        end
        case (s_q.st)
            gdp_pkg::ST_IDLE: begin
                s_d.cnt = 18'h00000;
                if (oc_raw != 3'h0 && resp != gdp_pkg::RESP_OFF) begin // R10
                    s_d.st    = gdp_pkg::ST_FILT;
                    s_d.phase = oc_raw;
                end
            end
            gdp_pkg::ST_FILT: begin
                if (oc_raw == 3'h0 || resp == gdp_pkg::RESP_OFF) begin
                    s_d.st = gdp_pkg::ST_IDLE;
                end else if (s_q.cnt + 18'h00001 >= deg_cycles(s_q.oc[gdp_pkg::OC_DEG +: 2])) begin
                    s_d.st    = gdp_pkg::ST_FAULT; // R11
                    s_d.cnt   = 18'h00000;
                    s_d.rep   = 1'b1;
                    s_d.phase = s_q.phase | oc_raw;
                    if (resp != gdp_pkg::RESP_REPORT) begin // R9
                        s_d.shut = s_q.scope ? 3'h7 : (s_q.phase | oc_raw); // R22
                    end
                end else begin
                    s_d.cnt = s_q.cnt + 18'h00001;
                end
            end
            gdp_pkg::ST_FAULT: begin
                s_d.cnt = s_q.cnt + 18'h00001;
                if (resp == gdp_pkg::RESP_RETRY) begin // R8
                    if ((s_q.ls[gdp_pkg::LS_CBC] && pwm_edge) // R1
                        || s_q.cnt + 18'h00001 >= (s_q.oc[gdp_pkg::OC_RETRY_INTERVAL_SELECT] // R5
                            ? 18'(gdp_pkg::RETRY_SHORT_CYC) : 18'(RETRY_LONG))) begin
                        s_d.st = gdp_pkg::ST_IDLE;
                    end
                end else if (resp == gdp_pkg::RESP_LATCH) begin
                    if (fault_clear) begin // R7
                        s_d.st = gdp_pkg::ST_IDLE;
                    end
                end else begin
                    if (oc_raw == 3'h0 || resp == gdp_pkg::RESP_OFF) begin
                        s_d.st = gdp_pkg::ST_IDLE;
                    end
                end
                if (s_d.st == gdp_pkg::ST_IDLE) begin
                    s_d.shut = 3'h0;
                    s_d.rep  = 1'b0;
                end
            end
            default: s_d.st = gdp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q        <= '0;
            s_q.ls     <= gdp_pkg::RST_LS_DRIVE;
            s_q.oc     <= gdp_pkg::RST_OC_CFG;
            s_q.sa     <= gdp_pkg::RST_SA_CFG;
            s_q.st     <= gdp_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata              = s_q.rdata;
    assign bridge_shutdown    = s_q.shut;
    assign fault_report       = s_q.rep;
    assign low_side_drive_cfg = s_q.ls;
    assign overcurrent_cfg    = s_q.oc;
    assign sense_amp_cfg      = HAS_AMP ? s_q.sa : 11'h000; // R15 R20

    a_lock_blocks: assert property (@(posedge ref_clk) disable iff (!rstn) // R21
        s_q.locked && wr_en && addr == gdp_pkg::ADDR_OC_CFG |=> $stable(s_q.oc))
        else $error("write accepted while locked");
    a_fet_forces_ref: assert property (@(posedge ref_clk) disable iff (!rstn) // R13
        !s_q.locked && wr_en && addr == gdp_pkg::ADDR_SA_CFG && wdata[10] && HAS_AMP
        |=> s_q.sa[gdp_pkg::SA_LSREF])
        else $error("low-side reference not forced");
    a_readback_ls: assert property (@(posedge ref_clk) disable iff (!rstn) // R23
        !s_q.locked && wr_en && addr == gdp_pkg::ADDR_LS_DRIVE ##1 rd_en
        && addr == gdp_pkg::ADDR_LS_DRIVE |=> rdata == $past(wdata, 2))
        else $error("readback mismatch");
    a_report_no_shut: assert property (@(posedge ref_clk) disable iff (!rstn) // R9
        resp == gdp_pkg::RESP_REPORT && s_q.st == gdp_pkg::ST_FILT
        && s_d.st == gdp_pkg::ST_FAULT |=> bridge_shutdown == 3'h0 && fault_report)
        else $error("report-only mode shut a bridge");
    a_off_silent: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
        resp == gdp_pkg::RESP_OFF && s_q.st != gdp_pkg::ST_FAULT
        |=> s_q.st != gdp_pkg::ST_FAULT && !fault_report)
        else $error("fault raised with response off");
    a_latch_holds: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
        s_q.st == gdp_pkg::ST_FAULT && resp == gdp_pkg::RESP_LATCH && !fault_clear
        |=> s_q.st == gdp_pkg::ST_FAULT)
        else $error("latched fault released");
    a_cbc_clear: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
        s_q.st == gdp_pkg::ST_FAULT && resp == gdp_pkg::RESP_RETRY && pwm_edge
        && s_q.ls[gdp_pkg::LS_CBC] |=> s_q.st == gdp_pkg::ST_IDLE && !fault_report)
        else $error("pwm edge did not clear fault");
    a_scope_all: assert property (@(posedge ref_clk) disable iff (!rstn) // R22
        s_q.scope && resp != gdp_pkg::RESP_REPORT && s_q.st == gdp_pkg::ST_FILT
        && s_d.st == gdp_pkg::ST_FAULT |=> bridge_shutdown == 3'h7)
        else $error("scope all did not shut three bridges");
endmodule

// >>> hw/gdp_pkg.sv
// gdp_pkg: offsets, field positions, reset values and timing constants of the
// gate drive protection configuration bank.
// assumes a 20 MHz ref_clk; included by name through gdp_pkg:: only.
package gdp_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned DATA_W        = 11;

    localparam logic [3:0]  ADDR_LS_DRIVE = 4'h4;
    localparam logic [3:0]  ADDR_OC_CFG   = 4'h5;
    localparam logic [3:0]  ADDR_SA_CFG   = 4'h6;
    localparam logic [3:0]  ADDR_LOCK     = 4'h8;
    localparam logic [3:0]  ADDR_STATUS   = 4'h9;
    localparam logic [3:0]  ADDR_ACTION   = 4'hA;

    localparam logic [10:0] RST_LS_DRIVE  = 11'h7FF;
    localparam logic [10:0] RST_OC_CFG    = 11'h169;
    localparam logic [10:0] RST_SA_CFG    = 11'h283;

    localparam logic [2:0]  LOCK_CODE     = 3'h6;
    localparam logic [2:0]  UNLOCK_CODE   = 3'h3;

    localparam int unsigned LS_CBC        = 10;
    localparam int unsigned LS_TDRV       = 8;
    localparam int unsigned LS_SRC        = 4;
    localparam int unsigned LS_SNK        = 0;
    localparam int unsigned OC_RETRY_INTERVAL_SELECT     = 10;
    localparam int unsigned OC_DEAD       = 8;
    localparam int unsigned OC_MODE       = 6;
    localparam int unsigned OC_DEG        = 4;
    localparam int unsigned OC_VDS        = 0;
    localparam int unsigned SA_FET        = 10;
    localparam int unsigned SA_DIV        = 9;
    localparam int unsigned SA_LSREF      = 8;
    localparam int unsigned SA_GAIN       = 6;
    localparam int unsigned SA_DIS        = 5;
    localparam int unsigned SA_CAL        = 2;
    localparam int unsigned SA_LVL        = 0;

    localparam logic [1:0]  RESP_LATCH    = 2'h0;
    localparam logic [1:0]  RESP_RETRY    = 2'h1;
    localparam logic [1:0]  RESP_REPORT   = 2'h2;
    localparam logic [1:0]  RESP_OFF      = 2'h3;

    // times in their own units, cycle counts derived
    localparam int unsigned RETRY_LONG_US  = 8000;
    localparam int unsigned RETRY_SHORT_US = 50;
    localparam int unsigned DEG_BASE_US    = 1;
    localparam int unsigned RETRY_LONG_CYC  = RETRY_LONG_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RETRY_SHORT_CYC = RETRY_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DEG_BASE_CYC    = DEG_BASE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W           = 18;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FILT  = 2'b01,
        ST_FAULT = 2'b11
    } gdp_state_t;
endpackage

// >>> tb/test_gdp_bank.sv
// test_gdp_bank: register bank and overcurrent sequencing checks, driven as software would.
// assumes gdp_bank with a shortened long retry interval of 200 cycles on a 50 ns clock.
`timescale 1ns/1ns
module test_gdp_bank;
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic        pwm     = 1'b0;
    logic        clr     = 1'b0;
    logic [3:0]  addr    = 4'h0;
    logic [10:0] wdata   = 11'h000;
    logic [2:0]  ds      = 3'h0;
    logic [2:0]  sh      = 3'h0;
    logic [10:0] rdata;
    logic [10:0] ls_cfg;
    logic [10:0] oc_cfg;
    logic [10:0] sa_cfg;
    logic [2:0]  sd;
    logic        rep;
    int          n_errors = 0;
    int          compares = 0;
    logic [10:0] pat [3] = '{11'h2A5, 11'h35A, 11'h0FC};

    gdp_bank #(.HAS_AMP(1'b1), .RETRY_LONG(200)) i_gdp_bank (
        .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .drain_source_overcurrent(ds),
        .shunt_overcurrent(sh), .pwm_edge(pwm), .fault_clear(clr),
        .bridge_shutdown(sd), .fault_report(rep), .low_side_drive_cfg(ls_cfg),
        .overcurrent_cfg(oc_cfg), .sense_amp_cfg(sa_cfg));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic final_report;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample at that negedge
    task automatic rd(input logic [3:0] a, input logic [10:0] e, input string nm);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        chk(nm, rdata, e);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic raw(input logic [2:0] d, input logic [2:0] s);
        @(posedge ref_clk);
        ds <= d;
        sh <= s;
    endtask

    task automatic pulse(input bit is_clr);
        @(posedge ref_clk);
        if (is_clr) clr <= 1'b1; else pwm <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        pwm <= 1'b0;
        cycles(3);
    endtask

    task automatic flt(input string nm, input logic [2:0] esd, input logic erep);
        chk(nm, {7'h00, rep, sd}, {7'h00, erep, esd});
    endtask

    // settle 30 cycles: the 20-cycle deglitch of code 00 has passed by then
    task automatic trip(input logic [10:0] oc, input logic [2:0] d, input logic [2:0] s);
        wr(gdp_pkg::ADDR_OC_CFG, oc);
        raw(d, s);
        cycles(30);
    endtask

    function automatic logic [10:0] occ(logic t, logic [1:0] m, logic [1:0] g);
        return {t, 2'h1, m, g, 4'h9};
    endfunction

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(gdp_pkg::ADDR_LS_DRIVE, 11'h7FF, "ls_reset");
        rd(gdp_pkg::ADDR_OC_CFG, 11'h169, "oc_reset");
        rd(gdp_pkg::ADDR_SA_CFG, 11'h283, "sa_reset");
        foreach (pat[i]) begin
            wr(4'h4 + 4'(i), pat[i]);
            rd(4'h4 + 4'(i), pat[i], "readback");
        end
        chk("oc_out", oc_cfg, 11'h35A);
        wr(gdp_pkg::ADDR_SA_CFG, 11'h400);
        rd(gdp_pkg::ADDR_SA_CFG, 11'h500, "amp_input");
        chk("sa_out", sa_cfg, 11'h500);
        rd(4'h3, 11'h000, "unmapped");
        wr(gdp_pkg::ADDR_LOCK, 11'h006);
        rd(gdp_pkg::ADDR_LOCK, 11'h001, "locked");
        wr(gdp_pkg::ADDR_LS_DRIVE, 11'h000);
        rd(gdp_pkg::ADDR_LS_DRIVE, 11'h2A5, "ls_locked");
        wr(gdp_pkg::ADDR_OC_CFG, 11'h000);
        rd(gdp_pkg::ADDR_OC_CFG, 11'h35A, "oc_locked");
        wr(gdp_pkg::ADDR_LOCK, 11'h003);
        wr(gdp_pkg::ADDR_LS_DRIVE, 11'h7FF);
        wr(gdp_pkg::ADDR_SA_CFG, 11'h283);
        cycles(1);
        chk("ls_out", ls_cfg, 11'h7FF);
        // deglitch code 01 needs 40 cycles of continuous high
        wr(gdp_pkg::ADDR_OC_CFG, occ(1'b1, gdp_pkg::RESP_LATCH, 2'h1));
        raw(3'h2, 3'h0);
        cycles(30);
        flt("filtering", 3'h0, 1'b0);
        cycles(20);
        flt("latched", 3'h2, 1'b1);
        raw(3'h0, 3'h0);
        cycles(10);
        flt("latch_held", 3'h2, 1'b1);
        pulse(1'b1);
        flt("latch_clear", 3'h0, 1'b0);
        trip(occ(1'b1, gdp_pkg::RESP_RETRY, 2'h0), 3'h1, 3'h0);
        raw(3'h0, 3'h0);
        pulse(1'b0);
        flt("pwm_clear", 3'h0, 1'b0);
        wr(gdp_pkg::ADDR_LS_DRIVE, 11'h3FF);
        trip(occ(1'b1, gdp_pkg::RESP_RETRY, 2'h0), 3'h1, 3'h0);
        raw(3'h0, 3'h0);
        pulse(1'b0);
        flt("pwm_ignored", 3'h1, 1'b1);
        cycles(880);
        flt("short_wait", 3'h1, 1'b1);
        cycles(200);
        flt("short_retry", 3'h0, 1'b0);
        trip(occ(1'b0, gdp_pkg::RESP_RETRY, 2'h0), 3'h4, 3'h0);
        raw(3'h0, 3'h0);
        cycles(120);
        flt("long_wait", 3'h4, 1'b1);
        cycles(150);
        flt("long_retry", 3'h0, 1'b0);
        wr(gdp_pkg::ADDR_LS_DRIVE, 11'h7FF);
        wr(gdp_pkg::ADDR_ACTION, 11'h001);
        trip(occ(1'b1, gdp_pkg::RESP_REPORT, 2'h0), 3'h4, 3'h0);
        flt("report_only", 3'h0, 1'b1);
        raw(3'h0, 3'h0);
        cycles(5);
        flt("report_gone", 3'h0, 1'b0);
        trip(occ(1'b1, gdp_pkg::RESP_RETRY, 2'h0), 3'h0, 3'h1);
        flt("all_bridges", 3'h7, 1'b1);
        raw(3'h0, 3'h0);
        pulse(1'b0);
        flt("scope_clear", 3'h0, 1'b0);
        wr(gdp_pkg::ADDR_SA_CFG, 11'h2A3);
        trip(occ(1'b1, gdp_pkg::RESP_RETRY, 2'h0), 3'h0, 3'h7);
        flt("shunt_masked", 3'h0, 1'b0);
        raw(3'h0, 3'h0);
        trip(occ(1'b1, gdp_pkg::RESP_OFF, 2'h0), 3'h7, 3'h0);
        flt("response_off", 3'h0, 1'b0);
        raw(3'h0, 3'h0);
        cycles(5);
        final_report();
    end
endmodule
